/* File: tcpwm_top.sv */
// Timer with counter and PWM modes behind an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module tcpwm_top
  import tcpwm_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    rst_in,
  // Avalon-MM slave
  input  wire logic [TCPWM_ADDR_W-1:0] avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [31:0]             avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic      [31:0]             avs_readdata_out,
  output logic                         avs_waitrequest_out,
  // Timer pins
  input  wire logic                    timer_in,
  output logic                         timer_out,
  output logic                         irq_out
);
  // ==========================================================
  // State
  logic [2:0]  ctrl_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic [15:0] match_r;
  logic [1:0]  status_r;
  logic [1:0]  mask_r;
  logic [2:0]  sync_r;
  logic        ack_r;
  logic        out_r;
  logic        irq_r;
  logic [31:0] rdata_r;

  logic        enable;
  logic        pol;
  tcpwm_mode_e mode;
  logic        edge_seen;
  logic        step;
  logic        at_reload;
  logic        at_match;
  logic        wr_go;
  logic        rd_go;
  logic        status_rd;

  assign enable    = ctrl_r[TCPWM_CTRL_EN_BIT];
  assign pol       = ctrl_r[TCPWM_CTRL_POL_BIT];
  assign mode      = tcpwm_mode_e'(ctrl_r[TCPWM_CTRL_MODE_BIT]);
  // ==========================================================
  // Input synchroniser; first stage feeds only the second
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], timer_in};
    end
  end

  // Polarity picks the edge: 1 rising, 0 falling
  assign edge_seen = (sync_r[2] != sync_r[1]) && (sync_r[1] == pol);
  assign step      = enable && ((mode == TCPWM_MODE_PWM) || edge_seen);
  assign at_reload = step && (count_r == reload_r);
  assign at_match  = step && (mode == TCPWM_MODE_PWM) && (count_r == match_r);

  // ==========================================================
  // Bus handshake: one wait cycle, then the answer
  assign wr_go     = avs_write_in && ack_r;
  assign rd_go     = avs_read_in && ack_r;
  assign status_rd = rd_go && (avs_address_in == TCPWM_ADDR_STATUS);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_in || avs_write_in) && !ack_r;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_r);
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // ==========================================================
  // Control register
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= TCPWM_CTRL_RST;
    end else if (wr_go && avs_address_in == TCPWM_ADDR_CTRL && avs_byteenable_in[0]) begin
      ctrl_r <= avs_writedata_in[2:0];
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reload_r <= TCPWM_RELOAD_RST;
      match_r  <= TCPWM_MATCH_RST;
      mask_r   <= TCPWM_IRQ_RST;
    end else if (wr_go) begin
      if (avs_address_in == TCPWM_ADDR_RELOAD) begin
        reload_r <= merge16(reload_r, avs_writedata_in, avs_byteenable_in);
      end
      if (avs_address_in == TCPWM_ADDR_MATCH) begin
        match_r <= merge16(match_r, avs_writedata_in, avs_byteenable_in);
      end
      if (avs_address_in == TCPWM_ADDR_MASK && avs_byteenable_in[0]) begin
        mask_r <= avs_writedata_in[1:0];
      end
    end
  end

  // ==========================================================
  // Counter; software start value holds only until first reload
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count_r <= TCPWM_COUNT_RST;
    end else if (wr_go && avs_address_in == TCPWM_ADDR_COUNT) begin
      count_r <= merge16(count_r, avs_writedata_in, avs_byteenable_in);
    end else if (at_reload) begin
      count_r <= TCPWM_RESTART;
    end else if (step) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ==========================================================
  // Output: idle level follows polarity even while disabled
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      out_r <= 1'b0;
    end else if (wr_go && avs_address_in == TCPWM_ADDR_CTRL && avs_byteenable_in[0]) begin
      // Starting level is taken with the control write, so enable and polarity may be written together
      out_r <= avs_writedata_in[TCPWM_CTRL_POL_BIT];
    end else if (!enable) begin
      out_r <= pol;
    end else if (mode == TCPWM_MODE_PWM && at_reload) begin
      out_r <= pol;
    end else if (at_match) begin
      out_r <= !out_r;
    end
  end
  assign timer_out = out_r;

  // ==========================================================
  // Sticky status; a new event beats the read-clear
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      status_r <= TCPWM_IRQ_RST;
    end else begin
      status_r[TCPWM_STS_RELOAD] <= at_reload || (status_r[TCPWM_STS_RELOAD] && !status_rd);
      status_r[TCPWM_STS_MATCH]  <= at_match || (status_r[TCPWM_STS_MATCH] && !status_rd);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end
  assign irq_out = irq_r;

  // ==========================================================
  // Read data, registered at the edge that first sees the request, one edge before acceptance; unmapped reads as zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= 32'h0000_0000;
    end else if ((avs_read_in || avs_write_in) && !ack_r) begin
      case (avs_address_in)
        TCPWM_ADDR_CTRL:   rdata_r <= {29'h0, ctrl_r};
        TCPWM_ADDR_COUNT:  rdata_r <= {16'h0, count_r};
        TCPWM_ADDR_RELOAD: rdata_r <= {16'h0, reload_r};
        TCPWM_ADDR_MATCH:  rdata_r <= {16'h0, match_r};
        TCPWM_ADDR_STATUS: rdata_r <= {30'h0, status_r};
        TCPWM_ADDR_MASK:   rdata_r <= {30'h0, mask_r};
        default:           rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_out = rdata_r;
endmodule : tcpwm_top
`default_nettype wire

/* File: tcpwm_pkg.sv */
// Package with register map, field positions, reset values and modes of the timer block
// Functional notes
// - Counter mode counts selected input edge
// - Edge select sets initial output level
// - Start count only for first pass
// - 16-bit reload value is terminal count
// - Transitions equal current count minus start
// - PWM mode counts every system clock
// - PWM toggles output at match value
// - At reload: interrupt, count 0001H, continue
// - Polarity one: start high, low at match
// - Polarity zero: start low, high at match
// - PWM leaves on timer output pin
package tcpwm_pkg;
  // ==========================================================
  // Register word addresses (one per 32-bit register)
  localparam logic [3:0]  TCPWM_ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  TCPWM_ADDR_COUNT    = 4'h1;
  localparam logic [3:0]  TCPWM_ADDR_RELOAD   = 4'h2;
  localparam logic [3:0]  TCPWM_ADDR_MATCH    = 4'h3;
  localparam logic [3:0]  TCPWM_ADDR_STATUS   = 4'h4;
  localparam logic [3:0]  TCPWM_ADDR_MASK     = 4'h5;
  localparam int          TCPWM_ADDR_W        = 4;
  // ==========================================================
  // Control and status field positions
  localparam int          TCPWM_CTRL_EN_BIT   = 0;
  localparam int          TCPWM_CTRL_MODE_BIT = 1;
  localparam int          TCPWM_CTRL_POL_BIT  = 2;
  localparam int          TCPWM_STS_RELOAD    = 0;
  localparam int          TCPWM_STS_MATCH     = 1;
  // ==========================================================
  // Reset values and the count loaded at reload
  localparam logic [15:0] TCPWM_COUNT_RST     = 16'h0001;
  localparam logic [15:0] TCPWM_RELOAD_RST    = 16'hFFFF;
  localparam logic [15:0] TCPWM_MATCH_RST     = 16'h0000;
  localparam logic [2:0]  TCPWM_CTRL_RST      = 3'h0;
  localparam logic [1:0]  TCPWM_IRQ_RST       = 2'h0;
  localparam logic [15:0] TCPWM_RESTART       = 16'h0001;
  // ==========================================================
  // Modes
  typedef enum logic {
    TCPWM_MODE_COUNTER = 1'b0,
    TCPWM_MODE_PWM     = 1'b1
  } tcpwm_mode_e;
endpackage : tcpwm_pkg

/* File: tcpwm_chk.sv */
// Timing checker for the timer bus and interrupt ports
`timescale 1ns/1ps
`default_nettype none
module tcpwm_chk (
  // Watched ports
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire logic req = avs_read_in || avs_write_in;
  wire logic ack = !avs_waitrequest_out;
  // ==========
  // Handshake, read data and interrupt
  sequence req_s; req && avs_waitrequest_out; endsequence
  sequence ack_s; ack ##1 avs_waitrequest_out; endsequence
  a_wait_one: assert property (req_s |=> ack_s) else $error("ack late");
  a_ack_single: assert property (ack |=> !ack) else $error("ack long");
  a_ack_cause: assert property (ack |-> $past(req)) else $error("ack unasked");
  a_idle_wait: assert property (!req && avs_waitrequest_out |=> avs_waitrequest_out) else $error("ack idle");
  a_rd_stands: assert property (avs_waitrequest_out && $past(avs_waitrequest_out) |-> $stable(avs_readdata_out))
    else $error("data moved");
  a_hole_zero: assert property (ack && avs_read_in && avs_address_in > 4'h5 |-> avs_readdata_out == 32'h0)
    else $error("hole data");
  a_sts_width: assert property (ack && avs_read_in && avs_address_in >= 4'h4 |-> avs_readdata_out[31:2] == 30'h0)
    else $error("wide status");
  a_irq_fall: assert property ($fell(irq_out) |-> !$past(avs_waitrequest_out) || !$past(avs_waitrequest_out, 2))
    else $error("irq lost");
endmodule : tcpwm_chk
bind tcpwm_top tcpwm_chk i_chk (.clock_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .irq_out);
`default_nettype wire

/* File: tcpwm_pin_model.sv */
// Model of the pad driving the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tcpwm_pin_model (
  // Clock and pin
  input  wire logic clock_in,
  output var  logic pin_out
);
  initial pin_out = 1'b0;
  // Levels held for several clocks so the synchroniser never misses one
  task automatic pulses(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge clock_in);
      pin_out <= 1'b1;
      repeat (gap) @(posedge clock_in);
      pin_out <= 1'b0;
    end
  endtask : pulses
endmodule : tcpwm_pin_model
`default_nettype wire

/* File: tcpwm_top_tb.sv */
// Self-checking bench of the timer block
`timescale 1ns/1ps
`default_nettype none
module tcpwm_top_tb;
  import tcpwm_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        lv;
  wire  [31:0] rq;
  wire         wq, tout, irq, pin;
  int          bad_count = 0, checked = 0, cyc = 0, seed = 36, r, m, n, s, d;
  tcpwm_top i_tcpwm_top (.clock_in, .rst_in, .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'h3), .avs_readdata_out(rq), .avs_waitrequest_out(wq),
    .timer_in(pin), .timer_out(tout), .irq_out(irq));
  tcpwm_pin_model i_tcpwm_pin_model (.clock_in, .pin_out(pin));
  initial forever #12.5 clock_in = ~clock_in;
  // ==========
  // Checks and bus cycles
  task automatic end_sim();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // The bench waits as long as the slave stalls; only the timeout ends it
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] dt);
    @(posedge clock_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= dt;
    do @(posedge clock_in); while (wq !== 1'b0);
    rdat = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    acc(0, TCPWM_ADDR_COUNT, 0);
    chk(rdat, 32'h1);
    acc(0, TCPWM_ADDR_RELOAD, 0);
    chk(rdat, 32'hFFFF);
    acc(0, 4'h9, 0);
    chk(rdat, 32'h0);
    for (int p = 1; p >= 0; p--) begin
      acc(1, TCPWM_ADDR_CTRL, 32'(p << TCPWM_CTRL_POL_BIT));
      repeat (2) @(posedge clock_in);
      chk(tout, 32'(p));
    end
    for (int p = 0; p < 2; p++) begin
      s = 1 + $unsigned($random(seed)) % 64;
      n = 2 + $unsigned($random(seed)) % 8;
      acc(1, TCPWM_ADDR_COUNT, 32'(s));
      acc(1, TCPWM_ADDR_CTRL, 32'((p << TCPWM_CTRL_POL_BIT) | 1));
      i_tcpwm_pin_model.pulses(n, 4 + 3 * p);
      repeat (8) @(posedge clock_in);
      acc(0, TCPWM_ADDR_COUNT, 0);
      chk(rdat, 32'(s + n));
    end
    acc(1, TCPWM_ADDR_CTRL, 32'h0);
    acc(0, TCPWM_ADDR_STATUS, 0);
    acc(1, TCPWM_ADDR_MASK, 32'h0);
    acc(1, TCPWM_ADDR_COUNT, 32'h1);
    acc(1, TCPWM_ADDR_RELOAD, 32'h3);
    acc(1, TCPWM_ADDR_CTRL, 32'h5);
    i_tcpwm_pin_model.pulses(5, 5);
    repeat (8) @(posedge clock_in);
    chk(irq, 32'h0);
    acc(0, TCPWM_ADDR_COUNT, 0);
    chk(rdat, 32'(5 % 3 + 1));
    acc(1, TCPWM_ADDR_MASK, 32'h1);
    repeat (3) @(posedge clock_in);
    chk(irq, 32'h1);
    acc(0, TCPWM_ADDR_STATUS, 0);
    chk(32'(rdat[0]), 32'h1);
    repeat (3) @(posedge clock_in);
    chk(irq, 32'h0);
    acc(1, TCPWM_ADDR_CTRL, 32'h0);
    for (int p = 0; p < 2; p++) begin
      r = 20 + $unsigned($random(seed)) % 20;
      m = 5 + $unsigned($random(seed)) % 10;
      acc(1, TCPWM_ADDR_COUNT, 32'h1);
      acc(1, TCPWM_ADDR_RELOAD, 32'(r));
      acc(1, TCPWM_ADDR_MATCH, 32'(m));
      acc(1, TCPWM_ADDR_CTRL, 32'((p << TCPWM_CTRL_POL_BIT) | 3));
      for (int i = 0; i < 5; i++) begin
        lv = tout;
        d = 0;
        while (tout === lv && d < 100) begin
          @(posedge clock_in);
          d++;
        end
        if (i > 0) chk(d, (lv === 1'(p)) ? m : r - m);
      end
      acc(0, TCPWM_ADDR_STATUS, 0);
      chk(rdat, 32'h3);
      acc(1, TCPWM_ADDR_CTRL, 32'h0);
    end
    end_sim();
  end
endmodule : tcpwm_top_tb
`default_nettype wire
